/* ilm_defines.svh */
// constants for the interrupt level mask block
// How it works
// - mask bit 7 gates level seven, fed by the eight port-four external pins
// - mask bit 6 gates level six, fed by the eight port-two external pins
// - mask bit 5 gates level five: both serial channels, transmit and receive
// - mask bit 4 gates level four: watch timer and synchronous serial port
// - mask bit 3 gates level three: timer D0/D1 match/capture and overflow
// - mask bit 2 gates level two: timer C match and overflow
// - mask bit 1 gates level one: timer B match only
// - mask bit 0 gates level zero: timer A match/capture and overflow
// - mask bit 0 hides level requests from the CPU, 1 passes them
`ifndef ILM_DEFINES_SVH
`define ILM_DEFINES_SVH

`define ILM_LEVEL_MASK_ADDR 8'hDD
`define ILM_MASK_RESET 8'h00
`define ILM_NUM_LEVELS 8
`define ILM_LEVEL_ZERO 0
`define ILM_LEVEL_ONE 1
`define ILM_LEVEL_TWO 2
`define ILM_LEVEL_THREE 3
`define ILM_LEVEL_FOUR 4
`define ILM_LEVEL_FIVE 5
`define ILM_LEVEL_SIX 6
`define ILM_LEVEL_SEVEN 7
`define ILM_MASKED 1'b0
`define ILM_UNMASKED 1'b1

`endif

/* ilm_pkg.sv */
// types shared by the interrupt level mask block
package ilm_pkg;

  // raw request lines from every source, grouped by peripheral
  typedef struct packed {
    logic [7:0] port_four_ext_pins;
    logic [7:0] port_two_ext_pins;
    logic uart0_tx;
    logic uart0_rx;
    logic uart1_tx;
    logic uart1_rx;
    logic watch_timer;
    logic sync_serial_port;
    logic timer_d0_match;
    logic timer_d0_ovf;
    logic timer_d1_match;
    logic timer_d1_ovf;
    logic timer_c_match;
    logic timer_c_ovf;
    logic timer_b_match;
    logic timer_a_match;
    logic timer_a_ovf;
  } ilm_src_t;

  // register-addressing access from the CPU core
  typedef struct packed {
    logic [7:0] addr;
    logic set1;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } ilm_reg_req_t;

  typedef enum logic [0:0] {
    ILM_ACC_IDLE,
    ILM_ACC_READ
  } ilm_acc_t;

endpackage

/* ilm_level_gate.sv */
// one interrupt level: collects its sources and applies its mask bit
`timescale 1ns/10ps
`default_nettype none
`include "ilm_defines.svh"
module ilm_level_gate #(
  parameter int WIDTH = 8
) (
  // sources and mask
  input wire logic [WIDTH-1:0] src,
  input wire logic enable,
  // results
  output logic requested,
  output logic passed
);

  assign requested = |src;
  // a masked level stays invisible to the CPU
  assign passed = requested & (enable == `ILM_UNMASKED);

endmodule
`default_nettype wire

/* ilm_top.sv */
// interrupt level mask register and level gating toward the CPU core
`timescale 1ns/10ps
`default_nettype none
`include "ilm_defines.svh"
module ilm_top #(
  parameter int LEVELS = `ILM_NUM_LEVELS,
  parameter logic [7:0] MASK_ADDR = `ILM_LEVEL_MASK_ADDR,
  parameter logic [7:0] MASK_RESET = `ILM_MASK_RESET
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  // register addressing from the CPU core
  input wire ilm_pkg::ilm_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_hit,
  // peripheral request lines
  input wire ilm_pkg::ilm_src_t src,
  // toward the CPU core
  output logic [7:0] level_req,
  output logic level_any,
  output logic [7:0] level_mask,
  output logic [7:0] level_raw
);

  // fans the sources of each level into an eight-wide lane, padded with zero
  // spare lane bits stay zero so the or-reduce in the gate never sees them
  function automatic logic [7:0] level_lane(input ilm_pkg::ilm_src_t s, input int lvl);
    logic [7:0] lane;
    lane = 8'h00;
    case (lvl)
      `ILM_LEVEL_SEVEN: begin
        lane = s.port_four_ext_pins;
      end
      `ILM_LEVEL_SIX: begin
        lane = s.port_two_ext_pins;
      end
      `ILM_LEVEL_FIVE: begin
        lane = {4'h0, s.uart1_rx, s.uart1_tx, s.uart0_rx, s.uart0_tx};
      end
      `ILM_LEVEL_FOUR: begin
        lane = {6'h00, s.sync_serial_port, s.watch_timer};
      end
      `ILM_LEVEL_THREE: begin
        lane = {4'h0, s.timer_d1_ovf, s.timer_d1_match, s.timer_d0_ovf, s.timer_d0_match};
      end
      `ILM_LEVEL_TWO: begin
        lane = {6'h00, s.timer_c_ovf, s.timer_c_match};
      end
      `ILM_LEVEL_ONE: begin
        lane = {7'h00, s.timer_b_match};
      end
      `ILM_LEVEL_ZERO: begin
        lane = {6'h00, s.timer_a_ovf, s.timer_a_match};
      end
      default: begin
        lane = 8'h00;
      end
    endcase
    return lane;
  endfunction

  // the mask lives in set 1 only; the same offset in other sets is not ours
  function automatic logic mask_selected(input ilm_pkg::ilm_reg_req_t r, input logic [7:0] a);
    return r.set1 && (r.addr == a);
  endfunction

  // mask register state
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  // read port state
  ilm_pkg::ilm_acc_t acc_q;
  ilm_pkg::ilm_acc_t acc_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  // gated and raw requests
  logic [7:0] req_q;
  logic [7:0] req_d;
  logic [7:0] raw_q;
  logic [7:0] raw_d;
  logic any_q;
  logic any_d;
  // combinational gate results
  logic [7:0] gate_req;
  logic [7:0] gate_pass;
  logic sel;

  assign sel = mask_selected(reg_req, MASK_ADDR);

  // accesses that hit the mask; ce is applied at the flops, so a frozen edge takes nothing
  logic wr_take;
  logic rd_take;
  assign wr_take = reg_req.wr && sel;
  assign rd_take = reg_req.rd && sel;

  // lanes built once per level, so gate and raw view share one grouping
  logic [7:0] lane [8];
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      lane[i] = level_lane(src, i);
    end
  end

  // one gate per level; levels beyond LEVELS read as idle

  genvar g;
  generate
    for (g = 0; g < LEVELS; g++) begin : g_level
      ilm_level_gate #(
        .WIDTH(8)
      ) u_gate (
        .src(lane[g]),
        .enable(mask_q[g]),
        .requested(gate_req[g]),
        .passed(gate_pass[g])
      );
    end
    for (g = LEVELS; g < 8; g++) begin : g_unused
      assign gate_req[g] = 1'b0;
      assign gate_pass[g] = 1'b0;
    end
  endgenerate

  // mask register: every write replaces all eight bits at once
  always_comb begin
    mask_d = mask_q;
    // a read in the same cycle still returns the old value
    if (wr_take) begin
      mask_d = reg_req.wdata;
    end
  end

  // read path: data registered, valid one cycle after the read strobe
  always_comb begin
    acc_d = ilm_pkg::ILM_ACC_IDLE;
    rdata_d = 8'h00;
    case (acc_q)
      ilm_pkg::ILM_ACC_IDLE: begin
        if (rd_take) begin
          acc_d = ilm_pkg::ILM_ACC_READ;
          rdata_d = mask_q;
        end
      end
      ilm_pkg::ILM_ACC_READ: begin
        // back-to-back reads keep valid up and refresh the data
        if (rd_take) begin
          acc_d = ilm_pkg::ILM_ACC_READ;
          rdata_d = mask_q;
        end
      end
      default: begin
        acc_d = ilm_pkg::ILM_ACC_IDLE;
        rdata_d = 8'h00;
      end
    endcase
  end

  // requests toward the CPU are registered so the core samples a clean level
  always_comb begin
    req_d = gate_pass;
    raw_d = gate_req;
    any_d = |gate_pass;
  end

  // mask flops; reset value is a choice, software still loads all eight bits first
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= MASK_RESET;
    end else if (ce) begin
      mask_q <= mask_d;
    end
  end

  // read port flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= ilm_pkg::ILM_ACC_IDLE;
      rdata_q <= 8'h00;
    end else if (ce) begin
      acc_q <= acc_d;
      rdata_q <= rdata_d;
    end
  end

  // request flops; while ce is low the core keeps the last sampled levels
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= 8'h00;
      raw_q <= 8'h00;
      any_q <= 1'b0;
    end else if (ce) begin
      req_q <= req_d;
      raw_q <= raw_d;
      any_q <= any_d;
    end
  end

  // register-side outputs
  assign reg_rdata = rdata_q;
  assign reg_rvalid = (acc_q == ilm_pkg::ILM_ACC_READ);
  // hit ignores ce: it only says the address is ours
  assign reg_hit = sel & (reg_req.rd | reg_req.wr);

  // level-side outputs, all straight from flops
  assign level_req = req_q;
  assign level_any = any_q;
  assign level_mask = mask_q;
  assign level_raw = raw_q;

endmodule
`default_nettype wire

/* ilm_top_monitor.sv */
// port checks for the level mask block
`timescale 1ns/10ps
`default_nettype none
module ilm_top_monitor #(
  parameter logic [7:0] MASK_ADDR = 8'hDD
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  // register access
  input wire ilm_pkg::ilm_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_hit,
  // levels
  input wire ilm_pkg::ilm_src_t src,
  input wire logic [7:0] level_req,
  input wire logic level_any,
  input wire logic [7:0] level_mask,
  input wire logic [7:0] level_raw
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_hit; reg_hit == ((reg_req.rd | reg_req.wr) & reg_req.set1 & (reg_req.addr == MASK_ADDR)); endproperty
  a_hit: assert property (p_hit) else $error("select mismatch");
  property p_wr; ce && reg_req.wr && reg_hit |=> level_mask == $past(reg_req.wdata); endproperty
  a_wr: assert property (p_wr) else $error("mask not loaded");
  property p_rd; ce && reg_req.rd && reg_hit |=> reg_rvalid && reg_rdata == $past(level_mask); endproperty
  a_rd: assert property (p_rd) else $error("bad read data");
  // a write in the same cycle only reaches the gate one cycle later
  property p_gate; ce && !reg_req.wr |=> level_req == (level_raw & $past(level_mask)); endproperty
  a_gate: assert property (p_gate) else $error("gating wrong");
  property p_sub; (level_req & ~level_raw) == 8'h00; endproperty
  a_sub: assert property (p_sub) else $error("request without source");
  property p_any; level_any == |level_req; endproperty
  a_any: assert property (p_any) else $error("summary wrong");
  // rst_n in the antecedent: the release edge still resets the flops
  property p_l7; rst_n && ce |=> level_raw[7] == |$past(src.port_four_ext_pins); endproperty
  a_l7: assert property (p_l7) else $error("level seven source");
  property p_l6; rst_n && ce |=> level_raw[6] == |$past(src.port_two_ext_pins); endproperty
  a_l6: assert property (p_l6) else $error("level six source");
  property p_l5;
    rst_n && ce |=> level_raw[5] == ($past(src.uart0_tx) | $past(src.uart0_rx) |
      $past(src.uart1_tx) | $past(src.uart1_rx));
  endproperty
  a_l5: assert property (p_l5) else $error("level five source");
  property p_l4; rst_n && ce |=> level_raw[4] == ($past(src.watch_timer) | $past(src.sync_serial_port)); endproperty
  a_l4: assert property (p_l4) else $error("level four source");
  property p_l3;
    rst_n && ce |=> level_raw[3] == ($past(src.timer_d0_match) | $past(src.timer_d0_ovf) |
      $past(src.timer_d1_match) | $past(src.timer_d1_ovf));
  endproperty
  a_l3: assert property (p_l3) else $error("level three source");
  property p_l2; rst_n && ce |=> level_raw[2] == ($past(src.timer_c_match) | $past(src.timer_c_ovf)); endproperty
  a_l2: assert property (p_l2) else $error("level two source");
  property p_l1; rst_n && ce |=> level_raw[1] == $past(src.timer_b_match); endproperty
  a_l1: assert property (p_l1) else $error("level one source");
  property p_l0; rst_n && ce |=> level_raw[0] == ($past(src.timer_a_match) | $past(src.timer_a_ovf)); endproperty
  a_l0: assert property (p_l0) else $error("level zero source");
endmodule
`default_nettype wire

/* ilm_src_model.sv */
// peripheral request model, one of two sources per level, timer B match alone for level one
`timescale 1ns/10ps
`default_nettype none
module ilm_src_model (
  // level commands
  input wire logic [7:0] lvl,
  input wire logic alt,
  // request lines
  output var ilm_pkg::ilm_src_t src
);
  always_comb begin
    src = '0;
    src.port_four_ext_pins = {8{lvl[7]}} & (alt ? 8'h80 : 8'h01);
    src.port_two_ext_pins = {8{lvl[6]}} & (alt ? 8'h80 : 8'h01);
    {src.uart1_rx, src.uart0_tx} = {2{lvl[5]}} & {alt, ~alt};
    {src.sync_serial_port, src.watch_timer} = {2{lvl[4]}} & {alt, ~alt};
    {src.timer_d1_ovf, src.timer_d0_match} = {2{lvl[3]}} & {alt, ~alt};
    {src.timer_c_ovf, src.timer_c_match} = {2{lvl[2]}} & {alt, ~alt};
    src.timer_b_match = lvl[1];
    {src.timer_a_ovf, src.timer_a_match} = {2{lvl[0]}} & {alt, ~alt};
  end
endmodule
`default_nettype wire

/* test_ilm_top.sv */
// self-checking bench for the level mask block
`timescale 1ns/10ps
`default_nettype none
module test_ilm_top;
  logic ref_clk = 0, rst_n = 0, ce = 1, alt = 0, reg_rvalid, reg_hit, level_any;
  logic [7:0] lvl = 8'h00, reg_rdata, level_req, level_mask, level_raw;
  ilm_pkg::ilm_reg_req_t reg_req = '0;
  ilm_pkg::ilm_src_t src;
  int fail_count = 0, checks = 0;
  // mask, active levels
  logic [7:0] rows [6][2] = '{'{8'hFF, 8'hFF}, '{8'h55, 8'hFF}, '{8'hAA, 8'h0F},
    '{8'h80, 8'hC0}, '{8'h01, 8'h03}, '{8'h3C, 8'hFF}};
  ilm_top ilm_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_hit(reg_hit), .src(src), .level_req(level_req), .level_any(level_any),
    .level_mask(level_mask), .level_raw(level_raw));
  ilm_src_model ilm_src_model_inst (.lvl(lvl), .alt(alt), .src(src));
  always #10 ref_clk = ~ref_clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic rd, input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_req <= '{addr: a, set1: 1'b1, wr: !rd, rd: rd, wdata: d};
    @(posedge ref_clk);
    chk({7'h00, reg_hit}, {7'h00, a == 8'hDD});
    reg_req <= '0;
    #1;
    chk(reg_rdata, exp);
    chk({7'h00, reg_rvalid}, {7'h00, rd && ce && a == 8'hDD});
  endtask
  task automatic complete_run;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    chk(level_mask, 8'h00);
    rst_n <= 1;
    foreach (rows[i]) begin
      acc(0, 8'hDD, rows[i][0], 8'h00);
      @(posedge ref_clk);
      lvl <= rows[i][1];
      alt <= 1'(i);
      repeat (2) @(posedge ref_clk);
      #1;
      chk(level_req, rows[i][0] & rows[i][1]);
      chk(level_raw, rows[i][1]);
      chk({7'h00, level_any}, {7'h00, |(rows[i][0] & rows[i][1])});
      acc(1, 8'hDD, 8'h00, rows[i][0]);
    end
    // unmapped place must neither load nor answer
    acc(0, 8'hDC, 8'h00, 8'h00);
    chk(level_mask, 8'h3C);
    acc(1, 8'hDC, 8'h00, 8'h00);
    @(posedge ref_clk);
    ce <= 0;
    acc(0, 8'hDD, 8'hFF, 8'h00);
    chk(level_mask, 8'h3C);
    @(posedge ref_clk);
    ce <= 1;
    // reset in mid-run: back to all masked while the sources stay up
    @(posedge ref_clk);
    rst_n <= 0;
    @(posedge ref_clk);
    #1;
    chk(level_mask, 8'h00);
    chk(level_raw, 8'h00);
    chk(reg_rdata, 8'h00);
    @(posedge ref_clk);
    rst_n <= 1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(level_raw, 8'hFF);
    chk(level_req, 8'h00);
    chk({7'h00, level_any}, 8'h00);
    complete_run();
  end
  initial begin
    #100000;
    fail_count++;
    complete_run();
  end
endmodule
bind ilm_top ilm_top_monitor #(.MASK_ADDR(MASK_ADDR)) ilm_top_monitor_inst (.ref_clk(ref_clk), .rst_n(rst_n),
  .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_hit(reg_hit), .src(src),
  .level_req(level_req), .level_any(level_any), .level_mask(level_mask), .level_raw(level_raw));
`default_nettype wire
